// >>> hdl/nhc_cycle.sv
// single command, address or data strobe cycle on the nand pins
`timescale 1ns/100ps
`default_nettype none
module nhc_cycle (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic start_i, // pulse: begin a cycle
  input wire nhc_pkg::nhc_kind_t kind_i, // cycle kind
  input wire logic [7:0] data_i, // byte to drive
  input wire logic [7:0] io_i, // device data pins
  output logic done_o, // pulse: cycle over
  output logic [7:0] rdata_o, // byte sampled on read
  output nhc_pkg::nhc_pin_t pins_o // strobes and data, ce and wp unused
);
  import nhc_pkg::*;

  typedef enum logic [2:0] {C_IDLE = 3'b001, C_LOW = 3'b010, C_HIGH = 3'b100} nhc_cst_t;
  nhc_cst_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic rd_r, rd_nxt;
  logic done_r, done_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  nhc_pin_t pin_r, pin_nxt;

  // strobe timing: low phase then high phase, both counted
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    pin_nxt = pin_r;
    case (st_r)
      C_IDLE: begin
        if (start_i) begin
          st_nxt = C_LOW;
          rd_nxt = (kind_i == K_RD);
          cnt_nxt = (kind_i == K_RD) ? T_RP_C : T_WP_C;
          pin_nxt.cle = (kind_i == K_CMD);
          pin_nxt.ale = (kind_i == K_ADDR); // address held through the rising strobe
          pin_nxt.io = data_i;
          pin_nxt.io_oe = (kind_i != K_RD);
          pin_nxt.we_n = (kind_i == K_RD);
          pin_nxt.re_n = (kind_i != K_RD);
        end
      end
      C_LOW: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          st_nxt = C_HIGH;
          cnt_nxt = rd_r ? T_REH_C : T_WH_C;
          pin_nxt.we_n = 1'b1; // rising edge latches byte
          pin_nxt.re_n = 1'b1;
          if (rd_r) begin
            rdata_nxt = io_i; // sampled before read strobe rises
          end
        end
      end
      C_HIGH: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          st_nxt = C_IDLE;
          done_nxt = 1'b1;
          pin_nxt.cle = 1'b0;
          pin_nxt.ale = 1'b0;
          pin_nxt.io_oe = 1'b0;
        end
      end
      default: st_nxt = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= C_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      pin_r <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0, io_oe: 1'b0, io: 8'h00};
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      pin_r <= pin_nxt;
    end
  end

  assign done_o = done_r;
  assign rdata_o = rdata_r;
  assign pins_o = pin_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_strobe_excl;
    !(!pin_r.we_n && !pin_r.re_n);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");

  property p_we_width;
    $fell(pin_r.we_n) |-> !pin_r.we_n [*3] ##1 pin_r.we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

  property p_no_drive_on_read;
    !pin_r.re_n |-> !pin_r.io_oe;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus driven during read");

  property p_ale_held;
    (pin_r.ale && !pin_r.we_n) |=> pin_r.ale;
  endproperty
  a_ale_held: assert property (p_ale_held) else $error("address latch dropped before strobe rise");
endmodule : nhc_cycle
`default_nettype wire

// >>> hdl/nhc_host.sv
// nand host controller: wishbone registers and operation sequencer
`timescale 1ns/100ps
`default_nettype none
module nhc_host (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [4:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic [7:0] io_i, // device data pins in
  input wire logic ready_busy_n_i, // device ready, low busy
  output nhc_pkg::nhc_pin_t pins_o // device pins out
);
  import nhc_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_ISSUE = 5'b00010, S_WAITC = 5'b00100, S_TWB = 5'b01000, S_RDY = 5'b10000
  } nhc_st_t;

  nhc_st_t st_r, st_nxt;
  nhc_op_t op_r, op_nxt;
  logic [2:0] step_r, step_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  logic [3:0] wb_cnt_r, wb_cnt_nxt;
  logic [31:0] id_r, id_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [7:0] last_cmd_r, last_cmd_nxt;
  logic pe_r, pe_nxt; // last busy command was program or erase
  logic cache_r, cache_nxt; // last busy command was 15h
  logic stat_pe_r, stat_pe_nxt;
  logic stat_cache_r, stat_cache_nxt;
  logic in_seq_r, in_seq_nxt;
  logic [ROW_W-BLK_LSB-1:0] seq_blk_r, seq_blk_nxt;
  logic copy_r, copy_nxt;
  logic wp_en_r, wp_en_nxt;
  logic err_r, err_nxt;
  logic seq_err_r, seq_err_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;

  logic cyc_done;
  logic [7:0] cyc_rdata;
  nhc_pin_t cyc_pins;
  nhc_step_t cur;
  logic wr_ctrl, wr_row, wr_stat, rd_en;
  nhc_op_t req_op;
  logic [7:0] req_byte;
  logic ovr_busy, ovr_seq;

  // result is meaningful only after program/erase and with its ready bit set
  function automatic logic nhc_pf_valid(input logic pe, input logic rdy);
    nhc_pf_valid = pe & rdy;
  endfunction : nhc_pf_valid

  assign cur = nhc_step(op_r, step_r, byte_r, row_r);
  assign rd_en = wb_cyc_i & wb_stb_i & ~ack_r & ~wb_we_i;
  assign wr_ctrl = wb_cyc_i & wb_stb_i & ~ack_r & wb_we_i & (wb_adr_i == REG_CTRL);
  assign wr_row = wb_cyc_i & wb_stb_i & ~ack_r & wb_we_i & (wb_adr_i == REG_ROW);
  assign wr_stat = wb_cyc_i & wb_stb_i & ~ack_r & wb_we_i & (wb_adr_i == REG_STAT) & wb_sel_i[0];
  assign req_op = nhc_op_t'(wb_dat_i[CTRL_OP_LSB +: 3]);
  assign req_byte = wb_dat_i[CTRL_BYTE_LSB +: 8];
  // while busy only status read and reset may go out
  assign ovr_busy = ~ready_busy_n_i &
                    ~((req_op == OP_STATUS) || (req_op == OP_RESET) ||
                      ((req_op == OP_CMD) && ((req_byte == CMD_STATUS) || (req_byte == CMD_RESET))));
  // 15h only inside a sequence whose block has not changed
  assign ovr_seq = (req_op == OP_CMD) && (req_byte == CMD_PROG_CACHE) &&
                   (~in_seq_r || (row_r[ROW_W-1:BLK_LSB] != seq_blk_r));

  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    dat_nxt = 32'h0000_0000;
    if (rd_en) begin
      case (wb_adr_i)
        REG_CTRL: dat_nxt = {15'h0000, wp_en_r, byte_r, 5'h00, op_r};
        REG_ROW: dat_nxt = {17'h00000, row_r};
        REG_STAT: dat_nxt = {24'h000000,
                             nhc_pf_valid(stat_pe_r & stat_cache_r, stat_r[ST_DC_RDY]),
                             nhc_pf_valid(stat_pe_r, stat_r[ST_PB_RDY]),
                             copy_r, seq_err_r, err_r, ready_busy_n_i, in_seq_r, st_r != S_IDLE};
        REG_RDATA: dat_nxt = {16'h0000, stat_r, rdata_r};
        REG_ID: dat_nxt = id_r;
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // sequencer: issues pin cycles, then waits for the device to go ready
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    step_nxt = step_r;
    byte_nxt = byte_r;
    row_nxt = row_r;
    wb_cnt_nxt = wb_cnt_r;
    id_nxt = id_r;
    rdata_nxt = rdata_r;
    stat_nxt = stat_r;
    last_cmd_nxt = last_cmd_r;
    pe_nxt = pe_r;
    cache_nxt = cache_r;
    stat_pe_nxt = stat_pe_r;
    stat_cache_nxt = stat_cache_r;
    in_seq_nxt = in_seq_r;
    seq_blk_nxt = seq_blk_r;
    copy_nxt = copy_r;
    wp_en_nxt = wp_en_r;
    err_nxt = err_r;
    seq_err_nxt = seq_err_r;
    // write one to clear; a new event in the same cycle wins below
    if (wr_stat) begin
      err_nxt = err_r & ~wb_dat_i[3];
      seq_err_nxt = seq_err_r & ~wb_dat_i[4];
    end
    if (wr_row && (st_r == S_IDLE)) begin
      row_nxt = wb_dat_i[ROW_W-1:0];
    end
    case (st_r)
      S_IDLE: begin
        if (wr_ctrl) begin
          wp_en_nxt = wb_dat_i[CTRL_WP_EN];
          if (ovr_busy) begin
            err_nxt = 1'b1;
          end else if (ovr_seq) begin
            seq_err_nxt = 1'b1;
          end else begin
            op_nxt = req_op;
            byte_nxt = req_byte;
            step_nxt = 3'h0;
            st_nxt = S_ISSUE;
          end
        end
      end
      S_ISSUE: st_nxt = S_WAITC;
      S_WAITC: begin
        if (cyc_done) begin
          if (cur.kind == K_CMD) begin
            last_cmd_nxt = cur.data; // a raw 70h turns later reads into status reads
          end
          if (cur.kind == K_CMD && cur.data != CMD_STATUS) begin
            case (cur.data)
              CMD_SERIAL_IN: begin
                if (~in_seq_r) begin
                  in_seq_nxt = 1'b1; // cached sequence opens on its block
                  seq_blk_nxt = row_r[ROW_W-1:BLK_LSB];
                end
              end
              CMD_COPY_READ, CMD_COPY_PROG: copy_nxt = 1'b1;
              CMD_PROG_END: begin
                in_seq_nxt = 1'b0; // a copy keeps write protect off until ready
              end
              CMD_RESET: begin
                in_seq_nxt = 1'b0; // abort may lose earlier cached page too
                copy_nxt = 1'b0;
              end
              default: in_seq_nxt = in_seq_r;
            endcase
            if (nhc_busy_cmd(cur.data)) begin
              pe_nxt = (cur.data == CMD_PROG_END) || (cur.data == CMD_PROG_CACHE) ||
                       (cur.data == CMD_ERASE_GO);
              cache_nxt = (cur.data == CMD_PROG_CACHE);
            end
          end
          if (cur.kind == K_RD) begin
            rdata_nxt = cyc_rdata;
            if (op_r == OP_ID) begin
              id_nxt = {cyc_rdata, id_r[31:8]}; // first byte lands lowest
            end
            if (op_r == OP_STATUS || last_cmd_r == CMD_STATUS) begin
              stat_nxt = cyc_rdata;
              stat_pe_nxt = pe_r;
              stat_cache_nxt = cache_r;
            end
          end
          if (!cur.last) begin
            step_nxt = step_r + 3'h1;
            st_nxt = S_ISSUE;
          end else if (cur.wait_rb) begin
            wb_cnt_nxt = T_WB_C;
            st_nxt = S_TWB;
          end else begin
            st_nxt = S_IDLE;
          end
        end
      end
      S_TWB: begin
        wb_cnt_nxt = wb_cnt_r - 4'h1;
        if (wb_cnt_r == 4'h1) begin
          st_nxt = S_RDY;
        end
      end
      S_RDY: begin
        if (ready_busy_n_i) begin
          st_nxt = S_IDLE; // done only once the device is ready
          if (last_cmd_r == CMD_PROG_END) begin
            copy_nxt = 1'b0; // last copied page programmed: protect may return
          end
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= S_IDLE;
      op_r <= OP_CMD;
      step_r <= 3'h0;
      byte_r <= 8'h00;
      row_r <= ROW_RST;
      wb_cnt_r <= 4'h0;
      id_r <= 32'h0000_0000;
      rdata_r <= 8'h00;
      stat_r <= 8'h00;
      last_cmd_r <= 8'h00;
      pe_r <= 1'b0;
      cache_r <= 1'b0;
      stat_pe_r <= 1'b0;
      stat_cache_r <= 1'b0;
      in_seq_r <= 1'b0;
      seq_blk_r <= '0;
      copy_r <= 1'b0;
      wp_en_r <= 1'b0;
      err_r <= 1'b0;
      seq_err_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      step_r <= step_nxt;
      byte_r <= byte_nxt;
      row_r <= row_nxt;
      wb_cnt_r <= wb_cnt_nxt;
      id_r <= id_nxt;
      rdata_r <= rdata_nxt;
      stat_r <= stat_nxt;
      last_cmd_r <= last_cmd_nxt;
      pe_r <= pe_nxt;
      cache_r <= cache_nxt;
      stat_pe_r <= stat_pe_nxt;
      stat_cache_r <= stat_cache_nxt;
      in_seq_r <= in_seq_nxt;
      seq_blk_r <= seq_blk_nxt;
      copy_r <= copy_nxt;
      wp_en_r <= wp_en_nxt;
      err_r <= err_nxt;
      seq_err_r <= seq_err_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  nhc_cycle u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(st_r == S_ISSUE),
    .kind_i(cur.kind),
    .data_i(cur.data),
    .io_i(io_i),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .pins_o(cyc_pins)
  );

  // chip stays selected; write protect forced off during a copy
  always_comb begin
    pins_o = cyc_pins;
    pins_o.ce_n = 1'b0;
    pins_o.wp_n = wp_en_r | copy_r;
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_busy_refused;
    (st_r == S_IDLE && wr_ctrl && !ready_busy_n_i && req_op == OP_ERASE) |=> (st_r == S_IDLE) && err_r;
  endproperty
  a_busy_refused: assert property (p_busy_refused) else $error("command issued while busy");

  property p_hold_until_ready;
    (st_r == S_RDY && !ready_busy_n_i) |=> (st_r == S_RDY);
  endproperty
  a_hold_until_ready: assert property (p_hold_until_ready) else $error("left wait before ready");

  property p_ready_ends;
    (st_r == S_RDY && ready_busy_n_i) |=> (st_r == S_IDLE);
  endproperty
  a_ready_ends: assert property (p_ready_ends) else $error("ready not followed by idle");

  property p_wp_in_copy;
    copy_r |-> pins_o.wp_n;
  endproperty
  a_wp_in_copy: assert property (p_wp_in_copy) else $error("write protect low during copy");

  property p_block_change;
    (st_r == S_IDLE && wr_ctrl && ready_busy_n_i && req_op == OP_CMD && req_byte == CMD_PROG_CACHE &&
     in_seq_r && row_r[ROW_W-1:BLK_LSB] != seq_blk_r) |=> seq_err_r && (st_r == S_IDLE);
  endproperty
  a_block_change: assert property (p_block_change) else $error("cache program across block change");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
endmodule : nhc_host
`default_nettype wire

// >>> pkg/nhc_pkg.sv
// package: constants, types and step decoding for the nand host controller
// Overview of operation
// - 15h after data load starts cached program
// - 10h ends cached program; ready when done
// - block change refuses 15h with a sequence error
// - 70h then read strobes return status
// - copy ends 8Ch-10h with write protect high
// - copy data input only where bytes change
// - erase is 60h then D0h, starts on strobe
// - only 70h or FFh while device busy
package nhc_pkg;
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 25; // least write strobe low time
  localparam int T_WH_NS = 15; // least write strobe high time
  localparam int T_RP_NS = 25; // least read strobe low time
  localparam int T_REH_NS = 15; // least read strobe high time
  localparam int T_WB_NS = 100; // longest delay before busy shows
  localparam logic [3:0] T_WP_C = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] T_WH_C = 4'((T_WH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] T_RP_C = 4'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] T_REH_C = 4'((T_REH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] T_WB_C = 4'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  // device commands
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_PROG_END = 8'h10;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
  localparam logic [7:0] CMD_READ_CACHE = 8'h31;
  localparam logic [7:0] CMD_READ_START = 8'h30;
  localparam logic [7:0] CMD_READ_LAST = 8'h3f;
  localparam logic [7:0] CMD_COPY_READ = 8'h3a;
  localparam logic [7:0] CMD_COPY_PROG = 8'h8c;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] ID_ADDR = 8'h00;
  // status byte bit positions
  localparam int ST_CUR_FAIL = 0;
  localparam int ST_PREV_FAIL = 1;
  localparam int ST_PB_RDY = 5;
  localparam int ST_DC_RDY = 6;
  localparam int ST_NOT_WP = 7;
  // register byte offsets and fields
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ROW = 5'h04;
  localparam logic [4:0] REG_STAT = 5'h08;
  localparam logic [4:0] REG_RDATA = 5'h0c;
  localparam logic [4:0] REG_ID = 5'h10;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BYTE_LSB = 8;
  localparam int CTRL_WP_EN = 16;
  localparam int BLK_LSB = 6;
  localparam int ROW_W = 15;
  localparam logic [ROW_W-1:0] ROW_RST = 15'h0000;

  typedef enum logic [1:0] {K_CMD = 2'h0, K_ADDR = 2'h1, K_WR = 2'h2, K_RD = 2'h3} nhc_kind_t;
  typedef enum logic [2:0] {
    OP_CMD = 3'h0, OP_ADDR = 3'h1, OP_WR = 3'h2, OP_RD = 3'h3,
    OP_STATUS = 3'h4, OP_ID = 3'h5, OP_ERASE = 3'h6, OP_RESET = 3'h7
  } nhc_op_t;

  // device side pins, driven from flip-flops except ce_n (tied low) and wp_n (or of two flops)
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic io_oe;
    logic [7:0] io;
  } nhc_pin_t;

  typedef struct packed {
    nhc_kind_t kind;
    logic [7:0] data;
    logic last;
    logic wait_rb;
  } nhc_step_t;

  // commands after which the device goes busy
  function automatic logic nhc_busy_cmd(input logic [7:0] c);
    nhc_busy_cmd = (c == CMD_PROG_END) || (c == CMD_PROG_CACHE) || (c == CMD_ERASE_GO) ||
                   (c == CMD_READ_START) || (c == CMD_READ_CACHE) || (c == CMD_READ_LAST) ||
                   (c == CMD_COPY_READ) || (c == CMD_RESET);
  endfunction : nhc_busy_cmd

  // pin cycle for a given operation and step
  function automatic nhc_step_t nhc_step(input nhc_op_t op, input logic [2:0] st, input logic [7:0] b,
                                         input logic [ROW_W-1:0] row);
    nhc_step = '{kind: K_CMD, data: b, last: 1'b1, wait_rb: 1'b0};
    case (op)
      OP_CMD: nhc_step.wait_rb = nhc_busy_cmd(b);
      OP_ADDR: nhc_step.kind = K_ADDR;
      OP_WR: nhc_step.kind = K_WR;
      OP_RD: nhc_step.kind = K_RD;
      OP_STATUS: begin
        nhc_step.kind = (st == 3'h0) ? K_CMD : K_RD;
        nhc_step.data = CMD_STATUS;
        nhc_step.last = (st != 3'h0);
      end
      OP_ID: begin
        nhc_step.kind = (st == 3'h0) ? K_CMD : ((st == 3'h1) ? K_ADDR : K_RD);
        nhc_step.data = (st == 3'h0) ? CMD_ID : ID_ADDR;
        nhc_step.last = (st == 3'h5);
      end
      OP_ERASE: begin
        nhc_step.kind = (st == 3'h1 || st == 3'h2) ? K_ADDR : K_CMD;
        case (st)
          3'h0: nhc_step.data = CMD_ERASE_SETUP;
          3'h1: nhc_step.data = row[7:0];
          3'h2: nhc_step.data = {1'b0, row[ROW_W-1:8]};
          default: nhc_step.data = CMD_ERASE_GO;
        endcase
        nhc_step.last = (st == 3'h3);
        nhc_step.wait_rb = 1'b1;
      end
      default: begin
        nhc_step.data = CMD_RESET;
        nhc_step.wait_rb = 1'b1;
      end
    endcase
  endfunction : nhc_step
endpackage : nhc_pkg

// >>> test/nhc_nand_model.sv
// behavioural nand device answering the host's strobes
`timescale 1ns/100ps
`default_nettype none
module nhc_nand_model #(
  parameter int BUSY_NS = 600, // short busy time for simulation
  parameter logic [31:0] IDS = 32'h15063c5a // bytes 1..4, low first; maker and device codes arbitrary
) (
  input wire nhc_pkg::nhc_pin_t pins_i, // host pins
  input wire logic fail_i, // next program or erase fails
  output logic [7:0] io_o, // data pins driven by the device
  output logic ready_busy_n_o, // ready line, pull-up resolved
  output logic [7:0] cmd_o, // last command other than status
  output logic [15:0] addr_o // last two address bytes
);
  logic pb_rdy = 1'b1, busy_req = 1'b0, cur_f = 1'b0, prev_f = 1'b0, st_mode = 1'b0, rb_r = 1'b1;
  logic [2:0] rd_i = 3'h0;
  logic [7:0] st;
  initial begin
    io_o = 8'h00;
    cmd_o = 8'h00;
    addr_o = 16'h0000;
  end
  // page buffer bit only differs from cache bit after cached commands
  assign st = {pins_i.wp_n, ready_busy_n_o, (cmd_o inside {8'h15, 8'h31}) ? pb_rdy : ready_busy_n_o,
               3'h0, prev_f, cur_f};
  // commands and addresses latch on the write strobe rise
  always @(posedge pins_i.we_n) begin
    if (pins_i.cle) begin
      st_mode = (pins_i.io == 8'h70);
      rd_i = 3'h0;
      if (pins_i.io != 8'h70) cmd_o = pins_i.io;
      if (pins_i.io inside {8'h10, 8'h15, 8'hd0, 8'hff}) begin
        prev_f = (pins_i.io == 8'hff) ? 1'b0 : cur_f;
        cur_f = fail_i && (pins_i.io != 8'hff);
        pb_rdy = 1'b0;
        busy_req = 1'b1;
      end
    end else if (pins_i.ale) begin
      addr_o = {addr_o[7:0], pins_i.io};
    end
  end
  // line goes low at the strobe of 10h, 15h, D0h or FFh, even while the timer still runs
  assign ready_busy_n_o = rb_r & ~busy_req;
  // busy timer; a new busy command, reset abort included, adds a full busy time once the running one ends
  always begin
    wait (busy_req);
    rb_r = 1'b0;
    busy_req = 1'b0;
    #(BUSY_NS + 1); // off the clock edge so the host never races the release
    if (cmd_o == 8'h15 && !busy_req) begin
      rb_r = 1'b1; // cache empty, page still programming
      #(BUSY_NS + 1);
    end
    if (!busy_req) begin
      rb_r = 1'b1;
      pb_rdy = 1'b1;
    end
  end
  // read strobe: status or id bytes; released pins show a changing value
  always @(negedge pins_i.re_n) begin
    io_o = st_mode ? st : ((cmd_o == 8'h90) ? IDS[8*rd_i +: 8] : 8'h00);
    rd_i = rd_i + 3'h1;
  end
  always @(posedge pins_i.re_n) io_o = ~io_o;
endmodule : nhc_nand_model
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the nand host controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import nhc_pkg::*;
  localparam logic [31:0] IDS = 32'h15063c5a; // arbitrary codes, 4 chips, 4 levels, 2 KB page
  logic clk = 0, rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, rb_n, fail = 0, wp_en = 1;
  logic [4:0] wb_adr = 5'h00;
  logic [31:0] wb_dat = 32'h0, wb_rdat, q;
  logic [7:0] dev_io, io_w, dev_cmd;
  logic [15:0] dev_addr;
  nhc_pin_t pins;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  assign io_w = pins.io_oe ? pins.io : dev_io;
  nhc_host uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .io_i(io_w), .ready_busy_n_i(rb_n), .pins_o(pins));
  nhc_nand_model #(.IDS(IDS)) dev (.pins_i(pins), .fail_i(fail), .io_o(dev_io), .ready_busy_n_o(rb_n),
    .cmd_o(dev_cmd), .addr_o(dev_addr));
  always #5 clk = ~clk;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // hang guard: whole run needs about 650 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // classic wishbone cycle, entered right after a rising edge
  task automatic wb_rw(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    // ack and data read at the rising edge, before that edge's update; only the hang guard ends this
    do @(posedge clk); while (wb_ack !== 1'b1);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask : wb_rw
  // start an operation and poll until the sequencer is idle
  task automatic run(input nhc_op_t op, input logic [7:0] b);
    wb_rw(1'b1, REG_CTRL, {15'h0, wp_en, b, 5'h0, op}, q);
    do wb_rw(1'b0, REG_STAT, 32'h0, q); while (q[0] !== 1'b0);
  endtask : run
  task automatic status_is(input string nm, input logic [7:0] e);
    run(OP_STATUS, 8'h00);
    wb_rw(1'b0, REG_RDATA, 32'h0, q);
    chk(nm, {24'h0, e}, {24'h0, q[15:8]});
  endtask : status_is
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("stat after reset", 32'h4, q);
    fail = 1'b1;
    wb_rw(1'b1, REG_ROW, 32'h1234, q);
    run(OP_ERASE, 8'h00);
    chk("erase address", 32'h3412, {16'h0, dev_addr});
    chk("erase confirm", 32'hd0, {24'h0, dev_cmd});
    status_is("erase status", 8'he1);
    $display("test erase done");
    fail = 1'b0;
    run(OP_CMD, CMD_SERIAL_IN);
    run(OP_CMD, CMD_PROG_CACHE);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("cached open", 32'h1, {31'h0, q[1]});
    status_is("cached status", 8'hc2);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("cached result valid", 32'h2, {30'h0, q[7:6]});
    fail = 1'b1;
    run(OP_CMD, CMD_PROG_END);
    status_is("last page status", 8'he1);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("cached closed", 32'h0, {31'h0, q[1]});
    chk("last result valid", 32'h1, {30'h0, q[7:6]});
    $display("test cached program done");
    run(OP_CMD, CMD_PROG_CACHE);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("sequence error", 32'h1, {31'h0, q[4]});
    wb_rw(1'b1, REG_STAT, 32'h10, q);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("sequence error clear", 32'h0, {31'h0, q[4]});
    run(OP_CMD, CMD_SERIAL_IN);
    wb_rw(1'b1, REG_ROW, 32'h0040, q);
    run(OP_CMD, CMD_PROG_CACHE);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("block change error", 32'h1, {31'h0, q[4]});
    $display("test sequence error done");
    wp_en = 1'b0;
    run(OP_RESET, 8'h00);
    chk("reset command", 32'hff, {24'h0, dev_cmd});
    status_is("status protected", 8'h60);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("reset result invalid", 32'h0, {30'h0, q[7:6]});
    $display("test reset done");
    run(OP_CMD, CMD_COPY_PROG);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("copy open", 32'h1, {31'h0, q[5]});
    chk("copy write enable", 32'h1, {31'h0, pins.wp_n});
    run(OP_CMD, CMD_PROG_END);
    wb_rw(1'b0, REG_STAT, 32'h0, q);
    chk("copy closed", 32'h0, {31'h0, q[5]});
    chk("copy protect back", 32'h0, {31'h0, pins.wp_n});
    run(OP_CMD, CMD_STATUS);
    run(OP_RD, 8'h00);
    wb_rw(1'b0, REG_RDATA, 32'h0, q);
    chk("raw status read", 32'h6161, {16'h0, q[15:0]});
    $display("test copy done");
    run(OP_ID, 8'h00);
    wb_rw(1'b0, REG_ID, 32'h0, q);
    chk("id bytes", IDS, q);
    $display("test id done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
